/* File: rtl/fsh_erase_cmd.v */
// serial flash command handler for erases, address mode and extended address read
// Overview of operation
// - 5Ch with four address bytes erases the 32KB half block to all ones.
// - DCh with four address bytes erases the 64KB block to all ones.
// - erases need the write enable latch, set by write enable; else rejected.
// - explicit wide erases always take exactly four address bytes.
// - any address inside a block selects the whole aligned block.
// - chip select must rise right after the last address bit or command drops.
// - chip select rise on valid erase starts timed cycle; busy flag high throughout.
// - write enable latch clears before the erase cycle completes.
// - block erases into protected area, per protect bits, are ignored.
// - C7h or 60h erase the whole array, with no address bytes.
// - whole-array erase needs chip select rise right after eighth opcode bit.
// - whole-array erase ignored while any block is protected.
// - B7h sets the wide address flag; address phases become 32-bit.
// - after reset the device uses 24-bit addresses.
// - in wide mode all commands work; address length changes and address frames reload the extended register.
// - E9h clears the wide address flag, back to 24-bit addresses.
// - C8h shifts the extended address byte out MSB first on falling clock.
// - in 24-bit mode the extended register supplies address bits 31 to 24.
// - in wide mode the extended register is not used for addresses.
// - all these commands also work over four lines in quad mode.
// - extended address register resets to zero.
// - in wide mode address bits 31 to 24 overwrite the extended register.
`timescale 1ns/1ps
`include "fsh_erase_map.vh"
module fsh_erase_cmd #(
  parameter [35:0] HALF_BLOCK_ERASE_CYCLES = `FSH_HBE_CYCLES,
  parameter [35:0] BLOCK_ERASE_CYCLES      = `FSH_BE_CYCLES,
  parameter [35:0] CHIP_ERASE_CYCLES       = `FSH_CE_CYCLES
) (
  // clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // serial pins
  input  wire        spi_clk,
  input  wire        spi_cs_n,
  input  wire [3:0]  spi_dq_in,
  output reg  [3:0]  spi_dq_out,
  output reg  [3:0]  spi_dq_oe,
  // protection settings
  input  wire        protect_complement,
  input  wire        protect_top_bottom,
  input  wire        protect_level_bit3,
  input  wire        protect_level_bit2,
  input  wire        protect_level_bit1,
  input  wire        protect_level_bit0,
  // status
  output reg         write_in_progress,
  output reg         write_enable_latch,
  output reg         wide_address_flag,
  output reg         quad_mode,
  output reg  [7:0]  ext_addr,
  // erase request to the array
  output reg         erase_start,
  output reg  [1:0]  erase_kind,
  output reg  [31:0] erase_base,
  output reg         erase_done
);

  // filtered pin levels
  wire [5:0] pin_level;
  wire       sclk_f;
  wire       csn_f;
  wire [3:0] dq_f;

  fsh_pin_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h10)
  ) u_sync (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .pin_in    ({spi_clk, spi_cs_n, spi_dq_in}),
    .pin_level (pin_level)
  );

  assign sclk_f = pin_level[5];
  assign csn_f  = pin_level[4];
  assign dq_f   = pin_level[3:0];

  reg        sclk_q;
  reg        csn_q;
  reg [5:0]  bit_cnt;
  reg [7:0]  opcode;
  reg [31:0] addr_sr;
  reg        rd_active;
  reg [7:0]  out_sr;
  reg [2:0]  out_cnt;
  reg [35:0] timer;

  wire sclk_rise = sclk_f & ~sclk_q & ~csn_f;
  wire sclk_fall = ~sclk_f & sclk_q & ~csn_f;
  wire cs_fall   = ~csn_f & csn_q;
  wire cs_rise   = csn_f & ~csn_q;
  wire [3:0] prot_level = {protect_level_bit3, protect_level_bit2,
                           protect_level_bit1, protect_level_bit0};

  // shift one bit or one nibble into a byte
  function [7:0] shift_byte;
    input [7:0] cur;
    input [3:0] dq;
    input       quad;
    begin
      if (quad) begin
        shift_byte = {cur[3:0], dq};
      end else begin
        shift_byte = {cur[6:0], dq[0]};
      end
    end
  endfunction

  // protection of one 64KB block; the nominal region grows from the top
  // or the bottom by powers of two, complement inverts it
  function prot_blk;
    input [9:0] blk;
    input       cmp;
    input       tb;
    input [3:0] lvl;
    reg   [10:0] span;
    reg          in_reg;
    begin
      if (lvl == 4'h0) begin
        span = 11'h000;
      end else if (lvl >= `FSH_BP_ALL_LEVEL) begin
        span = `FSH_BLK_COUNT;
      end else begin
        span = 11'h001 << (lvl - 4'h1);
      end
      if (tb) begin
        in_reg = ({1'b0, blk} < span);
      end else begin
        in_reg = ({1'b0, blk} >= (`FSH_BLK_COUNT - span));
      end
      prot_blk = cmp ^ in_reg;
    end
  endfunction

  // any block protected at all, for the whole-array erase
  wire any_protected = protect_complement ? (prot_level < `FSH_BP_ALL_LEVEL)
                                          : (prot_level != 4'h0);

  // decode of the frame that just closed
  reg  [5:0]  exp_len;
  reg         is_addr_cmd;
  reg  [1:0]  cmd_kind;
  reg  [31:0] cmd_addr;
  reg  [35:0] cmd_cycles;
  reg         cmd_blocked;

  always @* begin
    exp_len     = `FSH_LEN_OPCODE;
    is_addr_cmd = 1'b0;
    cmd_kind    = 2'h0;
    cmd_addr    = addr_sr;
    cmd_cycles  = 36'h0_0000_0000;
    case (opcode)
      `FSH_OP_HALF_BLK_WIDE: begin
        exp_len     = `FSH_LEN_ADDR4;
        is_addr_cmd = 1'b1;
        cmd_kind    = `FSH_KIND_HALF_BLK;
      end
      `FSH_OP_BLK_WIDE: begin
        exp_len     = `FSH_LEN_ADDR4;
        is_addr_cmd = 1'b1;
        cmd_kind    = `FSH_KIND_BLK;
      end
      `FSH_OP_HALF_BLK_ERASE: begin
        exp_len     = wide_address_flag ? `FSH_LEN_ADDR4 : `FSH_LEN_ADDR3;
        is_addr_cmd = 1'b1;
        cmd_kind    = `FSH_KIND_HALF_BLK;
      end
      `FSH_OP_BLK_ERASE: begin
        exp_len     = wide_address_flag ? `FSH_LEN_ADDR4 : `FSH_LEN_ADDR3;
        is_addr_cmd = 1'b1;
        cmd_kind    = `FSH_KIND_BLK;
      end
      `FSH_OP_CHIP_ERASE_A, `FSH_OP_CHIP_ERASE_B: begin
        cmd_kind = `FSH_KIND_CHIP;
      end
      default: begin
        cmd_kind = 2'h0;
      end
    endcase
    // three-byte frames borrow the top byte from the extended register
    if (is_addr_cmd && exp_len == `FSH_LEN_ADDR3) begin
      cmd_addr = {ext_addr, addr_sr[23:0]};
    end else begin
      cmd_addr = addr_sr;
    end
    case (cmd_kind)
      `FSH_KIND_HALF_BLK: begin
        cmd_addr    = cmd_addr & `FSH_HALF_BLK_MASK;
        cmd_cycles  = HALF_BLOCK_ERASE_CYCLES;
      end
      `FSH_KIND_BLK: begin
        cmd_addr    = cmd_addr & `FSH_BLK_MASK;
        cmd_cycles  = BLOCK_ERASE_CYCLES;
      end
      `FSH_KIND_CHIP: begin
        cmd_addr    = 32'h0000_0000;
        cmd_cycles  = CHIP_ERASE_CYCLES;
      end
      default: begin
        cmd_cycles  = 36'h0_0000_0000;
      end
    endcase
    if (cmd_kind == `FSH_KIND_CHIP) begin
      cmd_blocked = any_protected;
    end else begin
      cmd_blocked = prot_blk(cmd_addr[`FSH_ARRAY_MSB:`FSH_BLK_LSB],
                             protect_complement, protect_top_bottom, prot_level);
    end
  end

  // a frame counts only when chip select rises exactly on its last bit
  wire frame_exact = cs_rise && (bit_cnt == exp_len);
  wire erase_ok    = frame_exact && (cmd_kind != 2'h0) && write_enable_latch
                     && !write_in_progress && !cmd_blocked;

  // input shifting, one bit or one nibble per rising clock
  wire [6:0] cnt_sum  = {1'b0, bit_cnt} + (quad_mode ? 7'h04 : 7'h01);
  wire [7:0] op_next  = shift_byte(opcode, dq_f, quad_mode);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q    <= 1'b0;
      csn_q     <= 1'b1;
      bit_cnt   <= 6'h00;
      opcode    <= 8'h00;
      addr_sr   <= 32'h0000_0000;
      rd_active <= 1'b0;
    end else begin
      sclk_q <= sclk_f;
      csn_q  <= csn_f;
      if (cs_fall) begin
        bit_cnt   <= 6'h00;
        opcode    <= 8'h00;
        addr_sr   <= 32'h0000_0000;
        rd_active <= 1'b0;
      end else if (csn_f) begin
        rd_active <= 1'b0;
      end else if (sclk_rise) begin
        // saturate so an overlong frame never wraps back to a legal count
        bit_cnt <= (cnt_sum > {1'b0, `FSH_LEN_SAT}) ? `FSH_LEN_SAT : cnt_sum[5:0];
        if (bit_cnt < `FSH_LEN_OPCODE) begin
          opcode <= op_next;
          if (cnt_sum[5:0] == `FSH_LEN_OPCODE) begin
            rd_active <= (op_next == `FSH_OP_READ_EXT_ADDR) ||
                         (op_next == `FSH_OP_READ_STATUS);
          end
        end else if (quad_mode) begin
          addr_sr <= {addr_sr[27:0], dq_f};
        end else begin
          addr_sr <= {addr_sr[30:0], dq_f[0]};
        end
      end
    end
  end

  // read-out on falling clock; status is reloaded every byte so a poll
  // sees the busy flag drop without reselecting the device
  wire [7:0] status_byte = {6'h00, write_enable_latch, write_in_progress};
  wire [7:0] src_byte    = (opcode == `FSH_OP_READ_EXT_ADDR) ? ext_addr : status_byte;
  wire [7:0] out_data    = (out_cnt == 3'h0) ? src_byte : out_sr;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_sr     <= 8'h00;
      out_cnt    <= 3'h0;
      spi_dq_out <= 4'h0;
      spi_dq_oe  <= 4'h0;
    end else if (csn_f || cs_fall) begin
      out_cnt    <= 3'h0;
      spi_dq_oe  <= 4'h0;
    end else if (sclk_fall && rd_active) begin
      if (quad_mode) begin
        spi_dq_out <= out_data[7:4];
        spi_dq_oe  <= 4'hF;
        out_sr     <= {out_data[3:0], 4'h0};
        out_cnt    <= out_cnt + 3'h4;
      end else begin
        spi_dq_out <= {2'h0, out_data[7], 1'b0};
        spi_dq_oe  <= 4'h2;
        out_sr     <= {out_data[6:0], 1'b0};
        out_cnt    <= out_cnt + 3'h1;
      end
    end
  end

  // mode bits, latch, extended register and the erase timer
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      write_in_progress  <= 1'b0;
      write_enable_latch <= 1'b0;
      wide_address_flag  <= 1'b0;
      quad_mode          <= 1'b0;
      ext_addr           <= 8'h00;
      erase_start        <= 1'b0;
      erase_kind         <= 2'h0;
      erase_base         <= 32'h0000_0000;
      erase_done         <= 1'b0;
      timer              <= 36'h0_0000_0000;
    end else begin
      erase_start <= 1'b0;
      erase_done  <= 1'b0;
      if (write_in_progress) begin
        if (timer <= 36'h0_0000_0001) begin
          write_in_progress <= 1'b0;
          erase_done        <= 1'b1;
        end else begin
          timer <= timer - 36'h0_0000_0001;
        end
      end
      if (erase_ok) begin
        write_in_progress  <= 1'b1;
        write_enable_latch <= 1'b0;
        timer              <= cmd_cycles;
        erase_start        <= 1'b1;
        erase_kind         <= cmd_kind;
        erase_base         <= cmd_addr;
      end else if (frame_exact && !write_in_progress) begin
        if (opcode == `FSH_OP_WRITE_ENABLE) begin
          write_enable_latch <= 1'b1;
        end
      end
      // wide-mode frames carry a top byte that replaces the register
      if (frame_exact && is_addr_cmd && wide_address_flag) begin
        ext_addr <= addr_sr[31:24];
      end
      if (frame_exact) begin
        if (opcode == `FSH_OP_ENTER_WIDE) begin
          wide_address_flag <= 1'b1;
        end else if (opcode == `FSH_OP_EXIT_WIDE) begin
          wide_address_flag <= 1'b0;
        end else if (opcode == `FSH_OP_ENTER_QUAD) begin
          quad_mode <= 1'b1;
        end else if (opcode == `FSH_OP_EXIT_QUAD && quad_mode) begin
          quad_mode <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: rtl/fsh_erase_map.vh */
// opcodes, status bit positions, sizes and erase timing for the erase command block
`ifndef FSH_ERASE_MAP_VH
`define FSH_ERASE_MAP_VH

// opcodes
`define FSH_OP_WRITE_ENABLE   8'h06
`define FSH_OP_READ_STATUS    8'h05
`define FSH_OP_HALF_BLK_ERASE 8'h52
`define FSH_OP_BLK_ERASE      8'hD8
`define FSH_OP_HALF_BLK_WIDE  8'h5C
`define FSH_OP_BLK_WIDE       8'hDC
`define FSH_OP_CHIP_ERASE_A   8'hC7
`define FSH_OP_CHIP_ERASE_B   8'h60
`define FSH_OP_ENTER_WIDE     8'hB7
`define FSH_OP_EXIT_WIDE      8'hE9
`define FSH_OP_READ_EXT_ADDR  8'hC8
`define FSH_OP_ENTER_QUAD     8'h38
`define FSH_OP_EXIT_QUAD      8'hFF

// bit counts of complete command frames
`define FSH_LEN_OPCODE        6'h08
`define FSH_LEN_ADDR3         6'h20
`define FSH_LEN_ADDR4         6'h28
`define FSH_LEN_SAT           6'h3F

// status byte field positions
`define FSH_ST_WIP            0
`define FSH_ST_WEL            1

// array geometry: 512 Mbit, 64 KB blocks
`define FSH_ARRAY_MSB         25
`define FSH_BLK_LSB           16
`define FSH_BLK_COUNT         11'h400
`define FSH_BP_ALL_LEVEL      4'hB
`define FSH_HALF_BLK_MASK     32'hFFFF_8000
`define FSH_BLK_MASK          32'hFFFF_0000

// erase kinds
`define FSH_KIND_HALF_BLK     2'h1
`define FSH_KIND_BLK          2'h2
`define FSH_KIND_CHIP         2'h3

// erase durations as 125 MHz cycle counts: 200 ms, 300 ms and 120 s
`define FSH_HBE_CYCLES        36'h0_017D_7840
`define FSH_BE_CYCLES         36'h0_023C_3460
`define FSH_CE_CYCLES         36'h3_7E11_D600

`endif

/* File: rtl/fsh_pin_sync.v */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module fsh_pin_sync #(
  parameter           WIDTH     = 6,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             mclk,
  input  wire             reset_n,
  // raw pins and filtered levels
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_level
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer         i;

  // stage1 feeds stage2 only; a level counts once stage2 and stage3 agree
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1    <= RESET_VAL;
      stage2    <= RESET_VAL;
      stage3    <= RESET_VAL;
      pin_level <= RESET_VAL;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          pin_level[i] <= stage3[i];
        end
      end
    end
  end

endmodule

/* File: verification/fsh_erase_cmd_asserts.sv */
// port checks for the erase command block
`timescale 1ns/1ps
module fsh_erase_cmd_asserts #(
  parameter [35:0] HALF_BLOCK_ERASE_CYCLES = 36'h14,
  parameter [35:0] BLOCK_ERASE_CYCLES      = 36'h1E,
  parameter [35:0] CHIP_ERASE_CYCLES       = 36'h28
) (
  // clock and reset
  input logic        mclk,
  input logic        reset_n,
  // pins and protection
  input logic        spi_cs_n,
  input logic [3:0]  spi_dq_oe,
  input logic        protect_complement,
  input logic        protect_level_bit3,
  input logic        protect_level_bit2,
  input logic        protect_level_bit1,
  input logic        protect_level_bit0,
  // status and erase request
  input logic        write_in_progress,
  input logic        write_enable_latch,
  input logic        wide_address_flag,
  input logic        quad_mode,
  input logic [7:0]  ext_addr,
  input logic        erase_start,
  input logic [1:0]  erase_kind,
  input logic [31:0] erase_base,
  input logic        erase_done
);
  logic [35:0] busy_len;
  logic [35:0] dur;
  logic [3:0]  lvl;
  assign lvl = {protect_level_bit3, protect_level_bit2, protect_level_bit1, protect_level_bit0};
  assign dur = (erase_kind == 2'h1) ? HALF_BLOCK_ERASE_CYCLES :
               (erase_kind == 2'h2) ? BLOCK_ERASE_CYCLES : CHIP_ERASE_CYCLES;
  // busy cycles since the erase began
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) busy_len <= 36'h0;
    else if (erase_start) busy_len <= 36'h1;
    else if (write_in_progress) busy_len <= busy_len + 36'h1;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  start_busy_a: assert property (erase_start |-> write_in_progress && !$past(write_in_progress))
    else $error("erase began without a fresh busy flag");
  start_latch_a: assert property (erase_start |-> $past(write_enable_latch))
    else $error("erase began with the latch clear");
  done_latch_a: assert property (erase_done |-> !write_enable_latch && $past(write_in_progress))
    else $error("erase ended with latch set or without busy");
  busy_len_a: assert property ($fell(write_in_progress) |-> erase_done && busy_len == dur)
    else $error("busy length differs from the erase duration");
  base_align_a: assert property (erase_start |-> (erase_kind == 2'h1 && erase_base[14:0] == 15'h0) ||
    (erase_kind == 2'h2 && erase_base[15:0] == 16'h0) || (erase_kind == 2'h3 && erase_base == 32'h0))
    else $error("erase base not aligned to its kind");
  chip_prot_a: assert property (erase_start && erase_kind == 2'h3 |->
    (protect_complement ? lvl >= 4'hB : lvl == 4'h0))
    else $error("chip erase began with a protected block");
  oe_idle_a: assert property (spi_cs_n [*8] |-> spi_dq_oe == 4'h0)
    else $error("output driven while deselected");
  oe_lane_a: assert property (spi_dq_oe != 4'h0 |-> spi_dq_oe == (quad_mode ? 4'hF : 4'h2))
    else $error("output lanes do not match the mode");
  ext_hold_a: assert property ($changed(ext_addr) |-> wide_address_flag)
    else $error("extended address changed outside wide mode");
endmodule
bind fsh_erase_cmd fsh_erase_cmd_asserts #(
  .HALF_BLOCK_ERASE_CYCLES(HALF_BLOCK_ERASE_CYCLES),
  .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES),
  .CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES)
) u_chk (.*);

/* File: verification/fsh_host_model.sv */
// host serial controller model framing commands to the flash pins
`timescale 1ns/1ps
module fsh_host_model (
  // serial pins
  output logic       spi_clk,
  output logic       spi_cs_n,
  output logic [3:0] spi_dq_in,
  input  logic [3:0] spi_dq_out
);
  localparam int HALF = 80;
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_dq_in = 4'h5;
  end
  // clock idles low outside frames; unused lanes toggle so no stale level is trusted
  task automatic xfer(input logic [39:0] v, input int n, input logic q, input int nrd,
                      output logic [7:0] rd);
    int step;
    step = q ? 4 : 1;
    rd = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = n; i > 0; i -= step) begin
      spi_dq_in = q ? v[i-1 -: 4] : {~spi_dq_in[3:1], v[i-1]};
      #HALF spi_clk = 1'b1;
      #HALF spi_clk = 1'b0;
    end
    for (int i = 0; i < nrd * 8; i += step) begin
      spi_dq_in = ~spi_dq_in;
      #HALF spi_clk = 1'b1;
      rd = q ? {rd[3:0], spi_dq_out} : {rd[6:0], spi_dq_out[1]};
      #HALF spi_clk = 1'b0;
    end
    #HALF spi_cs_n = 1'b1;
    spi_dq_in = ~spi_dq_in;
    #200;
  endtask
endmodule

/* File: verification/fsh_erase_cmd_tb.sv */
// self-checking bench for the erase and address mode command block
`timescale 1ns/1ps
module fsh_erase_cmd_tb;
  localparam int HBE = 20;
  localparam int BE  = 30;
  localparam int CE  = 40;
  logic        mclk;
  logic        reset_n;
  logic        spi_clk;
  logic        spi_cs_n;
  logic [3:0]  spi_dq_in;
  logic [3:0]  spi_dq_out;
  logic [3:0]  spi_dq_oe;
  logic        protect_complement;
  logic        protect_top_bottom;
  logic        protect_level_bit3;
  logic        protect_level_bit2;
  logic        protect_level_bit1;
  logic        protect_level_bit0;
  logic        write_in_progress;
  logic        write_enable_latch;
  logic        wide_address_flag;
  logic        quad_mode;
  logic [7:0]  ext_addr;
  logic        erase_start;
  logic [1:0]  erase_kind;
  logic [31:0] erase_base;
  logic        erase_done;
  logic [1:0]  kind_q;
  logic [31:0] base_q;
  logic [7:0]  rd;
  logic        qd;
  int          fail_count = 0;
  int          check_count = 0;
  int          starts = 0;
  int          busy_cnt = 0;
  int          cycles = 0;
  fsh_erase_cmd #(
    .HALF_BLOCK_ERASE_CYCLES(36'(HBE)),
    .BLOCK_ERASE_CYCLES(36'(BE)),
    .CHIP_ERASE_CYCLES(36'(CE))
  ) dut (.*);
  fsh_host_model host (.*);
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (erase_start === 1'b1) begin
      starts++;
      kind_q = erase_kind;
      base_q = erase_base;
      busy_cnt = 0;
    end
    if (write_in_progress === 1'b1) busy_cnt++;
    if (cycles == 80000) begin
      fail_count++;
      test_done;
    end
  end
  task automatic test_done;
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic set_prot(input logic c, input logic t, input logic [3:0] l);
    protect_complement = c;
    protect_top_bottom = t;
    {protect_level_bit3, protect_level_bit2, protect_level_bit1, protect_level_bit0} = l;
  endtask
  task automatic pulse_reset;
    reset_n = 1'b0;
    repeat (5) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic send(input logic [39:0] v, input int n);
    host.xfer(v, n, qd, 0, rd);
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic rd_ext(input logic [7:0] exp);
    host.xfer(40'hC8, 8, qd, 1, rd);
    chk(rd, exp);
  endtask
  // refused frames must leave the latch as it was
  task automatic erase(input logic [39:0] v, input int n, input logic ok, input logic [1:0] k,
                       input logic [31:0] b, input int dur);
    int   s0;
    logic w0;
    s0 = starts;
    w0 = write_enable_latch;
    send(v, n);
    repeat (CE + 20) begin
      if (write_in_progress === 1'b1) begin
        @(posedge mclk);
        #1;
      end
    end
    chk(starts - s0, ok);
    chk(write_in_progress, 1'b0);
    chk(write_enable_latch, ok ? 1'b0 : w0);
    if (ok) begin
      chk(kind_q, k);
      chk(base_q, b);
      chk(busy_cnt, dur);
    end
  endtask
  initial begin
    mclk = 1'b0;
    qd = 1'b0;
    set_prot(1'b0, 1'b0, 4'h0);
    pulse_reset;
    chk(wide_address_flag, 1'b0);
    chk(ext_addr, 8'h00);
    rd_ext(8'h00);
    erase(40'h5C_0123_C567, 40, 1'b0, 2'h0, 32'h0, 0);
    send(40'h06, 8);
    host.xfer(40'h05, 8, qd, 1, rd);
    chk(rd, 8'h02);
    erase(40'h5C_0123_C567, 40, 1'b1, 2'h1, 32'h0123_8000, HBE);
    send(40'h06, 8);
    erase(40'hDC_02AB_CDEF, 40, 1'b1, 2'h2, 32'h02AB_0000, BE);
    send(40'h06, 8);
    // low 39 bits of this value open with the 64KB erase opcode
    erase(40'h6E_0155_E6F7, 39, 1'b0, 2'h0, 32'h0, 0);
    erase(40'h5C01_2345, 32, 1'b0, 2'h0, 32'h0, 0);
    erase(40'hC700, 16, 1'b0, 2'h0, 32'h0, 0);
    erase(40'hC7, 8, 1'b1, 2'h3, 32'h0, CE);
    send(40'h06, 8);
    erase(40'h60, 8, 1'b1, 2'h3, 32'h0, CE);
    send(40'h06, 8);
    set_prot(1'b0, 1'b0, 4'h1);
    erase(40'hDC_03FF_1234, 40, 1'b0, 2'h0, 32'h0, 0);
    erase(40'hC7, 8, 1'b0, 2'h0, 32'h0, 0);
    erase(40'hDC_0000_1234, 40, 1'b1, 2'h2, 32'h0, BE);
    send(40'h06, 8);
    set_prot(1'b0, 1'b1, 4'h1);
    erase(40'hDC_0000_1234, 40, 1'b0, 2'h0, 32'h0, 0);
    set_prot(1'b1, 1'b1, 4'h1);
    erase(40'hDC_0000_1234, 40, 1'b1, 2'h2, 32'h0, BE);
    set_prot(1'b0, 1'b0, 4'h0);
    send(40'hB7, 8);
    chk(wide_address_flag, 1'b1);
    send(40'h06, 8);
    erase(40'h52_7B01_0000, 40, 1'b1, 2'h1, 32'h7B01_0000, HBE);
    send(40'h06, 8);
    erase(40'h5C_5A01_0000, 40, 1'b1, 2'h1, 32'h5A01_0000, HBE);
    chk(ext_addr, 8'h5A);
    send(40'hE9, 8);
    chk(wide_address_flag, 1'b0);
    rd_ext(8'h5A);
    send(40'h06, 8);
    erase(40'h5201_8000, 32, 1'b1, 2'h1, 32'h5A01_8000, HBE);
    send(40'h38, 8);
    chk(quad_mode, 1'b1);
    qd = 1'b1;
    send(40'h06, 8);
    erase(40'hDC_0001_0000, 40, 1'b1, 2'h2, 32'h0001_0000, BE);
    rd_ext(8'h5A);
    send(40'hFF, 8);
    qd = 1'b0;
    chk(quad_mode, 1'b0);
    send(40'hB7, 8);
    // mid-run reset must drop wide mode and clear the extended register
    pulse_reset;
    chk(wide_address_flag, 1'b0);
    chk(ext_addr, 8'h00);
    test_done;
  end
endmodule
